// file: pkg/pcix_strap_defines.svh
// constants for the parallel-bus strap and pin-role block
// Contract
// [RULE_01] as bus master, drive wide request low to ask for 64-bit transfers
// [RULE_02] as target, wide request is an input only, never driven
// [RULE_03] as target, drive wide acknowledge low to accept 64-bit transfers
// [RULE_04] as bus master, wide acknowledge is an input only, never driven
// [RULE_05] seven fan-out clocks come from the reference clock input
// [RULE_06] bus reset low floats every parallel-bus output, without any clock
// [RULE_07] forward mode: four interrupt lines are async inputs, synchronised first
// [RULE_08] reverse mode: interrupt lines are open-drain outputs, pulled low to assert
// [RULE_09] an asserted interrupt stays until driver software clears it
// [RULE_10] bus-side logic runs on the feedback clock looped from a fan-out output; here it runs on mclk and only samples and watches that clock
// [RULE_11] clock generator enable decides whether fan-out clocks run
// [RULE_12] test strap low is normal operation, high is test functions
// [RULE_13] serial strap 0 picks eeprom master, 1 picks smbus slave
// [RULE_14] visibility strap 0 is transparent, 1 is non-transparent bridging
// [RULE_15] hot-plug strap high enables hot-plug operation
// [RULE_16] direction strap 0 is forward, 1 is reverse bridging
// [RULE_17] arbiter select low: internal arbiter grants the bus to masters
// [RULE_18] arbiter select high: an external arbiter arbitrates, bridge does not
// [RULE_19] external arbiter: request 0 is own grant in, grant 0 own request out
// [RULE_20] external arbiter: requests 5..2 are gp inputs, grants 5..2 gp outputs
// [RULE_21] reverse mode repurposes request 0, grant 0 and lines 5..2 likewise
// [RULE_22] straps are caught at bus reset release and held until next reset
`ifndef PCIX_STRAP_DEFINES_SVH
`define PCIX_STRAP_DEFINES_SVH

// ----------------------------------------
// register map, byte offsets
// ----------------------------------------
`define REG_MODE 4'h0
`define REG_CTRL 4'h4
`define REG_PINS 4'h8
`define CTRL_RST 12'h000
`define CTRL_W 12

// ----------------------------------------
// synchroniser vector layout
// ----------------------------------------
`define SYNC_W 21
`define SYNC_STRAP 0
`define SYNC_REQ 6
`define SYNC_IRQ 12
`define SYNC_WREQ 16
`define SYNC_WACK 17
`define SYNC_BRST 18
`define SYNC_CGEN 19
`define SYNC_FBCK 20
`define SYNC_RST 21'h03ffc0

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define NUM_REQ 6
`define NUM_GP 4
`define NUM_IRQ 4
`define NUM_FANOUT 7
`define FB_TIMEOUT 4'hf

`endif

// file: pkg/pcix_strap_pkg.sv
// types for the parallel-bus strap and pin-role block
package pcix_strap_pkg;

    typedef struct packed {
        logic clockGenRun;
        logic externalArb;
        logic reverseMode;
        logic hotplugEnable;
        logic nonTransparent;
        logic smbusSlave;
        logic testMode;
    } mode_t;

    typedef struct packed {
        logic [3:0] generalOutput;
        logic [3:0] irqAssert;
        logic ownBusRequest;
        logic wideAck;
        logic wideRequest;
        logic busMaster;
    } ctrl_t;

    typedef enum logic [2:0] {
        ARB_PARK = 3'b001,
        ARB_GRANT = 3'b010,
        ARB_EXT = 3'b100
    } arb_state_t;

endpackage : pcix_strap_pkg

// file: hdl/pcix_side_strap_and_pin_roles.sv
// strap decode and pin roles for the parallel-bus side
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "pcix_strap_defines.svh"

module pcix_side_strap_and_pin_roles
    import pcix_strap_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEnable,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic busReset_n,
    input wire logic referenceClockIn,
    input wire logic feedbackClockIn,
    input wire logic clockgenEnable,
    output logic [6:0] fanoutClockOut,
    input wire logic testStrap,
    input wire logic serialPortStrap,
    input wire logic bridgeVisibilityStrap,
    input wire logic hotplugStrap,
    input wire logic directionStrap,
    input wire logic arbiterSelect_n,
    input wire logic wideXferRequestIn_n,
    output logic wideXferRequestOut_n,
    output logic wideXferRequestOe,
    input wire logic wideXferAckIn_n,
    output logic wideXferAckOut_n,
    output logic wideXferAckOe,
    input wire logic [3:0] irqLineIn_n,
    output logic [3:0] irqLineOut_n,
    output logic [3:0] irqLineOe,
    input wire logic [5:0] busReqIn_n,
    output logic [5:0] busGntOut_n,
    output logic [5:0] busGntOe,
    output logic [3:0] generalInput,
    output logic externalGrant,
    output mode_t modes
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
logic [`SYNC_W-1:0] pinRaw;
logic [`SYNC_W-1:0] pinFilt;
localparam logic [`SYNC_W-1:0] SYNC_INIT = `SYNC_RST;

assign pinRaw = {
    feedbackClockIn,
    clockgenEnable,
    busReset_n,
    wideXferAckIn_n,
    wideXferRequestIn_n,
    irqLineIn_n,
    busReqIn_n,
    arbiterSelect_n,
    directionStrap,
    hotplugStrap,
    bridgeVisibilityStrap,
    serialPortStrap,
    testStrap
};

// bus-side state all runs on mclk; the looped-back feedback clock is only sampled and watched // [RULE_10]
genvar gi;
generate
    for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
        logic s1;
        logic s2;
        logic s3;
        logic f;
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                s1 <= SYNC_INIT[gi];
                s2 <= SYNC_INIT[gi];
                s3 <= SYNC_INIT[gi];
                f <= SYNC_INIT[gi];
            end else if (clkEnable) begin
                s1 <= pinRaw[gi];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    f <= s3;
                end
            end
        end
        assign pinFilt[gi] = f;
    end
endgenerate

// ----------------------------------------
// pin level decode
// ----------------------------------------

// filtered copies, idle levels come from the synchroniser reset
logic [`SYNC_W-1:0] pinLevel;
assign pinLevel = pinFilt;

logic [5:0] strapNow;
logic [5:0] reqNow_n;
logic [3:0] irqNow_n;
logic wideReqNow_n;
logic wideAckNow_n;
logic busResetNow_n;
logic clockGenNow;
logic fbNow;

assign strapNow = pinLevel[`SYNC_STRAP +: 6];
assign reqNow_n = pinLevel[`SYNC_REQ +: `NUM_REQ];
assign irqNow_n = pinLevel[`SYNC_IRQ +: `NUM_IRQ]; // [RULE_07]
assign wideReqNow_n = pinLevel[`SYNC_WREQ];
assign wideAckNow_n = pinLevel[`SYNC_WACK];
assign busResetNow_n = pinLevel[`SYNC_BRST];
assign clockGenNow = pinLevel[`SYNC_CGEN];
assign fbNow = pinLevel[`SYNC_FBCK];

// ----------------------------------------
// strap capture at bus reset release
// ----------------------------------------
logic busResetPrev_n;
logic clockGenRun;
logic [5:0] strapped;

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        busResetPrev_n <= 1'b0;
    end else if (clkEnable) begin
        busResetPrev_n <= busResetNow_n;
    end
end

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        strapped <= 6'h00;
    end else if (clkEnable && busResetNow_n && !busResetPrev_n) begin // [RULE_22]
        strapped[0] <= strapNow[0]; // [RULE_12]
        strapped[1] <= strapNow[1]; // [RULE_13]
        strapped[2] <= strapNow[2]; // [RULE_14]
        strapped[3] <= strapNow[3]; // [RULE_15]
        strapped[4] <= strapNow[4]; // [RULE_16]
        strapped[5] <= strapNow[5]; // [RULE_17] [RULE_18]
    end
end

// ----------------------------------------
// clock generator enable
// ----------------------------------------

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        clockGenRun <= 1'b0;
    end else if (clkEnable) begin
        clockGenRun <= clockGenNow; // [RULE_11]
    end
end

assign modes = {clockGenRun, strapped};

// ----------------------------------------
// clock fan-out
// ----------------------------------------
generate
    for (gi = 0; gi < `NUM_FANOUT; gi = gi + 1) begin : g_fanout
        assign fanoutClockOut[gi] = referenceClockIn & clockGenRun; // [RULE_05] [RULE_11]
    end
endgenerate

// ----------------------------------------
// feedback clock watch
// ----------------------------------------

logic fbPrev;
logic [3:0] fbIdle;
logic fbAlive;

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        fbPrev <= 1'b0;
        fbIdle <= `FB_TIMEOUT;
    end else if (clkEnable) begin
        fbPrev <= fbNow;
        if (fbNow != fbPrev) begin
            fbIdle <= 4'h0;
        end else if (fbIdle != `FB_TIMEOUT) begin
            fbIdle <= fbIdle + 4'h1;
        end
    end
end

assign fbAlive = (fbIdle != `FB_TIMEOUT);

// ----------------------------------------
// register bus slave
// ----------------------------------------
ctrl_t ctrl;
logic ack;
logic [31:0] next_readdata;
logic [31:0] pinsWord;
logic [5:0] grantVec;
logic repurpose;

assign waitrequest = (read | write) & ~ack;

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        ack <= 1'b0;
    end else if (clkEnable) begin
        ack <= (read | write) & ~ack;
    end
end

// ----------------------------------------
// register readback
// ----------------------------------------

always_comb begin
    next_readdata = 32'h00000000;
    case (address)
        `REG_MODE: begin
            next_readdata = {25'h0000000, modes};
        end
        `REG_CTRL: begin
            next_readdata = {20'h00000, ctrl};
        end
        `REG_PINS: begin
            next_readdata = pinsWord;
        end
        default: begin
            next_readdata = 32'h00000000;
        end
    endcase
end

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        readdata <= 32'h00000000;
    end else if (clkEnable && read && !ack) begin
        readdata <= next_readdata;
    end
end

// ----------------------------------------
// control register
// ----------------------------------------

// driver software sets and clears the reverse-mode interrupt bits
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl <= `CTRL_RST;
    end else if (clkEnable && write && ack && address == `REG_CTRL) begin
        ctrl <= writedata[`CTRL_W-1:0]; // [RULE_09]
    end
end

assign pinsWord = {
    14'h0000,
    fbAlive,
    grantVec,
    externalGrant,
    generalInput,
    ~irqNow_n,
    ~wideAckNow_n,
    ~wideReqNow_n
};

// ----------------------------------------
// bus arbiter and request/grant roles
// ----------------------------------------
arb_state_t arbState;
logic [5:0] reqActive;
logic [5:0] pick;

assign repurpose = modes.externalArb | modes.reverseMode; // [RULE_21]
assign reqActive = ~reqNow_n;
assign pick = reqActive & (~reqActive + 6'h01);

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        arbState <= ARB_PARK;
        grantVec <= 6'h00;
    end else if (clkEnable) begin
        case (arbState)
            ARB_PARK: begin
                grantVec <= 6'h00;
                if (repurpose) begin
                    arbState <= ARB_EXT;
                end else if (reqActive != 6'h00 && !ctrl.ownBusRequest) begin
                    grantVec <= pick; // [RULE_17]
                    arbState <= ARB_GRANT;
                end
            end
            ARB_GRANT: begin
                if (repurpose || (grantVec & reqActive) == 6'h00) begin
                    grantVec <= 6'h00;
                    arbState <= ARB_PARK;
                end
            end
            ARB_EXT: begin
                grantVec <= 6'h00; // [RULE_18]
                if (!repurpose) begin
                    arbState <= ARB_PARK;
                end
            end
            default: begin
                grantVec <= 6'h00;
                arbState <= ARB_PARK;
            end
        endcase
    end
end

// ----------------------------------------
// grant and general-purpose pins
// ----------------------------------------

always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        busGntOut_n <= 6'h3f;
        generalInput <= 4'h0;
        externalGrant <= 1'b0;
    end else if (clkEnable) begin
        if (repurpose) begin
            busGntOut_n[0] <= ~ctrl.ownBusRequest; // [RULE_19]
            busGntOut_n[1] <= 1'b1;
            busGntOut_n[5:2] <= ctrl.generalOutput; // [RULE_20]
            generalInput <= reqNow_n[5:2]; // [RULE_20]
            externalGrant <= ~reqNow_n[0]; // [RULE_19]
        end else begin
            busGntOut_n <= ~grantVec; // [RULE_17]
            generalInput <= 4'h0;
            externalGrant <= 1'b0;
        end
    end
end

// ----------------------------------------
// wide transfer and grant enable pin roles
// ----------------------------------------
logic busLive;

// raw pin, no clock involved in floating the bus
assign busLive = busReset_n & rst_n; // [RULE_06]

assign wideXferRequestOut_n = ~ctrl.wideRequest; // [RULE_01]
assign wideXferRequestOe = busLive & ctrl.busMaster; // [RULE_01] [RULE_02] [RULE_06]
assign wideXferAckOut_n = ~ctrl.wideAck; // [RULE_03]
assign wideXferAckOe = busLive & ~ctrl.busMaster; // [RULE_03] [RULE_04] [RULE_06]

assign busGntOe = {`NUM_REQ{busLive}}; // [RULE_06]

// ----------------------------------------
// interrupt pin roles
// ----------------------------------------
logic irqDrive;

assign irqDrive = busLive & modes.reverseMode; // [RULE_06] [RULE_08]

generate
    for (gi = 0; gi < `NUM_IRQ; gi = gi + 1) begin : g_irq
        assign irqLineOut_n[gi] = 1'b0; // [RULE_08]
        assign irqLineOe[gi] = irqDrive & ctrl.irqAssert[gi]; // [RULE_08] [RULE_09]
    end
endgenerate

endmodule : pcix_side_strap_and_pin_roles

// file: sim/pcix_strap_assertions.sv
// port checks for the strap and pin-role block
module pcix_strap_checker
    import pcix_strap_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEnable,
    input wire logic busReset_n,
    input wire logic referenceClockIn,
    input wire logic [5:0] busReqIn_n,
    input wire logic [6:0] fanoutClockOut,
    input wire logic wideXferRequestOe,
    input wire logic wideXferAckOe,
    input wire logic [3:0] irqLineOut_n,
    input wire logic [3:0] irqLineOe,
    input wire logic [5:0] busGntOut_n,
    input wire logic [5:0] busGntOe,
    input wire logic [3:0] generalInput,
    input wire logic externalGrant,
    input wire mode_t modes
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [3:0] relCnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) relCnt <= 4'h0;
        else if (!busReset_n) relCnt <= 4'h0;
        else if (relCnt != 4'hf) relCnt <= relCnt + 4'h1;
    end
    sequence settled_pins;
        ($stable(busReqIn_n) && $stable(modes) && clkEnable)[*8];
    endsequence
    oe_reset_a: assert property (
        !busReset_n |-> !(wideXferRequestOe || wideXferAckOe || |irqLineOe || |busGntOe))
        else $error("bus output enabled under bus reset");
    wide_role_a: assert property (
        busReset_n |-> wideXferRequestOe != wideXferAckOe)
        else $error("wide request and ack roles overlap");
    fanout_gate_a: assert property (
        fanoutClockOut == {7{referenceClockIn && modes.clockGenRun}})
        else $error("fanout clock mismatch");
    irq_forward_a: assert property (
        !modes.reverseMode |-> irqLineOe == 4'h0)
        else $error("irq driven in forward mode");
    irq_drain_a: assert property (
        |irqLineOe |-> modes.reverseMode && (irqLineOut_n & irqLineOe) == 4'h0)
        else $error("irq not open drain");
    modes_hold_a: assert property (
        relCnt == 4'hf |=> $stable(modes[5:0]))
        else $error("strapped modes changed");
    pin_repurpose_a: assert property (
        settled_pins ##0 (modes.externalArb || modes.reverseMode)
        |-> generalInput == busReqIn_n[5:2] && externalGrant == !busReqIn_n[0])
        else $error("repurposed inputs wrong");
    grant_onehot_a: assert property (
        $stable(modes) && !(modes.externalArb || modes.reverseMode)
        |-> $countones(~busGntOut_n) <= 1)
        else $error("more than one grant");
endmodule : pcix_strap_checker

bind pcix_side_strap_and_pin_roles pcix_strap_checker chk_i (.mclk, .rst_n, .clkEnable,
    .busReset_n, .referenceClockIn, .busReqIn_n, .fanoutClockOut, .wideXferRequestOe,
    .wideXferAckOe, .irqLineOut_n, .irqLineOe, .busGntOut_n, .busGntOe, .generalInput,
    .externalGrant, .modes);

// file: sim/pcix_bus_peer.sv
// peer devices on the parallel bus: clock source, pulled-up lines, external arbiter
module pcix_bus_peer (
    input wire logic [6:0] fanoutClockOut,
    input wire logic [5:0] busGntOut_n,
    input wire logic [5:0] busGntOe,
    input wire logic wideXferRequestOut_n,
    input wire logic wideXferRequestOe,
    input wire logic wideXferAckOut_n,
    input wire logic wideXferAckOe,
    input wire logic [3:0] irqLineOut_n,
    input wire logic [3:0] irqLineOe,
    input wire logic [5:0] peerReq,
    input wire logic [3:0] peerIrq,
    input wire logic [1:0] peerWide,
    input wire logic extArb,
    output logic referenceClockIn,
    output logic feedbackClockIn,
    output logic [5:0] gntLine,
    output logic [5:0] busReqIn_n,
    output logic wideXferRequestIn_n,
    output logic wideXferAckIn_n,
    output logic [3:0] irqLineIn_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        referenceClockIn = 1'b0;
        forever #15 referenceClockIn = ~referenceClockIn;
    end
    assign feedbackClockIn = fanoutClockOut[0];
    assign gntLine = busGntOut_n | ~busGntOe;
    assign busReqIn_n = {peerReq[5:1], extArb ? gntLine[0] : peerReq[0]};
    assign wideXferRequestIn_n = (wideXferRequestOut_n | ~wideXferRequestOe) & peerWide[0];
    assign wideXferAckIn_n = (wideXferAckOut_n | ~wideXferAckOe) & peerWide[1];
    assign irqLineIn_n = peerIrq & (irqLineOut_n | ~irqLineOe);
endmodule : pcix_bus_peer

// file: sim/tb_top.sv
// top-level bench for the strap and pin-role block
module tb_top
    import pcix_strap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, clkEnable, read, write, busReset_n, clockgenEnable, extArb;
    logic waitrequest, referenceClockIn, feedbackClockIn, externalGrant;
    logic wideXferRequestIn_n, wideXferRequestOut_n, wideXferRequestOe;
    logic wideXferAckIn_n, wideXferAckOut_n, wideXferAckOe;
    logic [3:0] address, peerIrq, generalInput, irqLineOut_n, irqLineOe, irqLineIn_n;
    logic [31:0] writedata, readdata, rdv;
    logic [1:0] peerWide;
    logic [5:0] straps, peerReq, busReqIn_n, busGntOut_n, busGntOe, gntLine;
    logic [6:0] fanoutClockOut;
    mode_t modes;
    int errTotal, cmpCount;
    pcix_side_strap_and_pin_roles dut (.mclk, .rst_n, .clkEnable, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .busReset_n, .referenceClockIn, .feedbackClockIn,
        .clockgenEnable, .fanoutClockOut, .testStrap(straps[0]), .serialPortStrap(straps[1]),
        .bridgeVisibilityStrap(straps[2]), .hotplugStrap(straps[3]), .directionStrap(straps[4]),
        .arbiterSelect_n(straps[5]), .wideXferRequestIn_n, .wideXferRequestOut_n,
        .wideXferRequestOe, .wideXferAckIn_n, .wideXferAckOut_n, .wideXferAckOe, .irqLineIn_n,
        .irqLineOut_n, .irqLineOe, .busReqIn_n, .busGntOut_n, .busGntOe, .generalInput,
        .externalGrant, .modes);
    pcix_bus_peer peer (.fanoutClockOut, .busGntOut_n, .busGntOe, .wideXferRequestOut_n,
        .wideXferRequestOe, .wideXferAckOut_n, .wideXferAckOe, .irqLineOut_n, .irqLineOe,
        .peerReq, .peerIrq, .peerWide, .extArb, .referenceClockIn, .feedbackClockIn, .gntLine,
        .busReqIn_n, .wideXferRequestIn_n, .wideXferAckIn_n, .irqLineIn_n);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic conclude();
        if (errTotal == 0 && cmpCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : xfer
    task automatic strap(input logic [5:0] s);
        straps <= s;
        busReset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({wideXferRequestOe, wideXferAckOe, irqLineOe, busGntOe}, 32'h0);
        busReset_n <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask : strap
    task automatic t_straps();
        logic [6:0] expMode;
        for (int i = 0; i < 6; i++) begin
            expMode = {1'b1, 6'h01 << i};
            strap(6'h01 << i);
            chk(modes[2:0], expMode[2:0]);
            chk(modes[6:3], expMode[6:3]);
            straps <= ~(6'h01 << i);
            repeat (10) @(posedge mclk);
            xfer(1'b0, 4'h0, 32'h0);
            chk(rdv, {25'h0, expMode});
        end
    endtask : t_straps
    task automatic t_wide();
        strap(6'h00);
        peerWide <= 2'b01;
        xfer(1'b1, 4'h4, 32'h3);
        repeat (8) @(posedge mclk);
        chk({wideXferRequestIn_n, wideXferAckOe}, 2'b00);
        xfer(1'b0, 4'h8, 32'h0);
        chk(rdv[1:0], 2'b11);
        peerWide <= 2'b10;
        xfer(1'b1, 4'h4, 32'h4);
        repeat (8) @(posedge mclk);
        chk({wideXferAckIn_n, wideXferRequestOe}, 2'b00);
        xfer(1'b0, 4'h8, 32'h0);
        chk(rdv[1:0], 2'b11);
        peerWide <= 2'b11;
    endtask : t_wide
    task automatic t_irq();
        strap(6'h00);
        peerIrq <= 4'hb;
        repeat (8) @(posedge mclk);
        xfer(1'b0, 4'h8, 32'h0);
        chk(rdv[5:2], 4'h4);
        peerIrq <= 4'hf;
        strap(6'h10);
        xfer(1'b1, 4'h4, 32'h50);
        repeat (20) @(posedge mclk);
        chk(irqLineIn_n, 4'ha);
        xfer(1'b1, 4'h4, 32'h0);
        chk(irqLineIn_n, 4'hf);
    endtask : t_irq
    task automatic t_repurpose();
        for (int i = 0; i < 2; i++) begin
            strap(6'h10 << i);
            extArb <= 1'b1;
            peerReq <= 6'h17;
            xfer(1'b1, 4'h4, 32'ha08);
            repeat (10) @(posedge mclk);
            chk(gntLine, 6'h2a);
            chk({generalInput, externalGrant}, {4'h5, 1'b1});
        end
        extArb <= 1'b0;
        peerReq <= 6'h3f;
    endtask : t_repurpose
    task automatic t_arb_clk();
        strap(6'h00);
        xfer(1'b1, 4'h4, 32'h0);
        peerReq <= 6'h27;
        repeat (10) @(posedge mclk);
        chk(gntLine, 6'h37);
        peerReq <= 6'h3f;
        xfer(1'b0, 4'h8, 32'h0);
        chk(rdv[17], 1'b1);
        clockgenEnable <= 1'b0;
        repeat (30) @(posedge mclk);
        chk(fanoutClockOut, 7'h00);
        xfer(1'b0, 4'h8, 32'h0);
        chk(rdv[17], 1'b0);
        clockgenEnable <= 1'b1;
        xfer(1'b0, 4'hc, 32'h0);
        chk(rdv, 32'h0);
    endtask : t_arb_clk
    initial begin
        {rst_n, busReset_n, read, write, extArb, address, writedata} = '0;
        {clkEnable, clockgenEnable, straps} = 8'hc0;
        {peerIrq, peerWide, peerReq} = 12'hfff;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_straps();
        t_wide();
        t_irq();
        t_repurpose();
        t_arb_clk();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        conclude();
    end
endmodule : tb_top
